// *** design/hspc_top.v ***
// four-channel high speed pulse counter
`timescale 1ns/100ps
`include "hspc_map.vh"

// Behaviour
// RQ1: four independent channels 0..3 each have their own fixed pin group a, b and z.
// RQ2: each channel selects increment, 4x quadrature, up/down or pulse plus direction input.
// RQ3: the pulse source keeps to 50 kHz in quadrature and 100 kHz otherwise.
// RQ4: each channel keeps a running present count that the host can read.
// RQ5: a one-cycle event is raised when a present count reaches its preset value.
// RQ6: each channel has a run enable that halts counting while keeping the count.
// RQ7: the count is offered as a periodic copy and as an on-demand latest read.
// RQ8: a speed figure is derived from the count change over a fixed window.
// RQ9: the present count is 32 bits, signed except in increment mode.
// RQ10: with software reset selected, the host reset bit clears the count.
// RQ11: quadrature counts every edge of a and b, up when a leads b, down otherwise.
module hspc_top #(
   parameter REFRESH_CYC = `HSPC_REFRESH_CYC,
   parameter SPEED_CYC = `HSPC_SPEED_CYC
) (
   input wire mclk,
   input wire rst_n,
   input wire [3:0] pin_a,
   input wire [3:0] pin_b,
   input wire [3:0] pin_z,
   input wire [7:0] method,
   input wire [3:0] run,
   input wire [3:0] soft_reset_sel,
   input wire [3:0] soft_reset,
   input wire [127:0] preset,
   input wire read_latest_count_instruction,
   input wire [1:0] read_chan,
   output reg [127:0] present_count,
   output reg [127:0] refreshed_count,
   output reg [31:0] latest_count,
   output reg latest_valid,
   output reg [127:0] speed,
   output reg [3:0] preset_hit
);

   // two-flop synchronisers, stage one feeds only stage two; the third flop
   // keeps the previous settled level for edge detection
   // limitation: all stages reset low, so a pin that rests high while reset
   // is released is seen as one rising edge three cycles later
   reg [3:0] a_s1, a_s2, a_d;
   reg [3:0] b_s1, b_s2, b_d;
   reg [3:0] z_s1, z_s2, z_d;

   // phase a, up and pulse pins
   always @(posedge mclk) begin
      if (!rst_n) begin
         a_s1 <= 4'h0;
         a_s2 <= 4'h0;
         a_d <= 4'h0;
      end else begin
         a_s1 <= pin_a;
         a_s2 <= a_s1;
         a_d <= a_s2;
      end
   end

   // phase b, down and direction pins
   always @(posedge mclk) begin
      if (!rst_n) begin
         b_s1 <= 4'h0;
         b_s2 <= 4'h0;
         b_d <= 4'h0;
      end else begin
         b_s1 <= pin_b;
         b_s2 <= b_s1;
         b_d <= b_s2;
      end
   end

   // phase z and reset pins
   always @(posedge mclk) begin
      if (!rst_n) begin
         z_s1 <= 4'h0;
         z_s2 <= 4'h0;
         z_d <= 4'h0;
      end else begin
         z_s1 <= pin_z;
         z_s2 <= z_s1;
         z_d <= z_s2;
      end
   end

   // refresh divider, one enable pulse per copy period
   reg [31:0] refresh_cnt;
   wire refresh_tick = (refresh_cnt == REFRESH_CYC - 1);
   always @(posedge mclk) begin
      if (!rst_n) begin
         refresh_cnt <= 32'h0;
      end else begin
         refresh_cnt <= refresh_tick ? 32'h0 : refresh_cnt + 32'h1;
      end
   end

   // speed window divider; a longer window gives finer speed but reacts slower
   reg [31:0] speed_cnt;
   wire speed_tick = (speed_cnt == SPEED_CYC - 1);
   always @(posedge mclk) begin
      if (!rst_n) begin
         speed_cnt <= 32'h0;
      end else begin
         speed_cnt <= speed_tick ? 32'h0 : speed_cnt + 32'h1;
      end
   end

   // per-channel step decode and count update
   // RQ1 four fixed pin groups
   // channel n owns bit n of every pin bus and word n of every 128-bit bus;
   // nothing but the two dividers and the latest-count read port is shared between channels
   reg [127:0] speed_base;
   genvar ch;
   generate
      for (ch = 0; ch < `HSPC_NCH; ch = ch + 1) begin : g_ch
         wire [1:0] m = method[2*ch +: 2];
         wire a = a_s2[ch];
         wire b = b_s2[ch];
         wire a_rise = a & ~a_d[ch];
         wire b_rise = b & ~b_d[ch];
         wire a_edge = a ^ a_d[ch];
         wire b_edge = b ^ b_d[ch];
         wire z_rise = z_s2[ch] & ~z_d[ch];
         reg up;
         reg dn;
         // RQ2 method select decode
         always @* begin
            up = 1'b0;
            dn = 1'b0;
            case (m)
               `HSPC_METH_INC: begin
                  up = a_rise;
               end
               // RQ11 quadrature direction
               `HSPC_METH_QUAD: begin
                  // both edges together is an illegal jump; it is dropped
                  if (a_edge & ~b_edge) begin
                     up = (a != b);
                     dn = (a == b);
                  end else if (b_edge & ~a_edge) begin
                     up = (a == b);
                     dn = (a != b);
                  end
               end
               // up and down pulses in one cycle cancel out
               `HSPC_METH_UPDN: begin
                  up = a_rise & ~b_rise;
                  dn = b_rise & ~a_rise;
               end
               // direction level high counts up
               `HSPC_METH_PDIR: begin
                  up = a_rise & b;
                  dn = a_rise & ~b;
               end
               default: begin
                  up = 1'b0;
                  dn = 1'b0;
               end
            endcase
         end
         // z/reset pin clears only in non-increment modes while the soft bit is on;
         // only the rising edge clears, so a z level held high does not pin the count
         wire hw_clr = (m != `HSPC_METH_INC) & z_rise & soft_reset[ch] & ~soft_reset_sel[ch];
         wire [31:0] cur = present_count[32*ch +: 32];
         // RQ9 32-bit wrap arithmetic
         wire [31:0] next_count = up ? cur + 32'h1 : (dn ? cur - 32'h1 : cur);
         // clear outranks the run gate so a stopped channel can still be zeroed
         always @(posedge mclk) begin
            if (!rst_n) begin
               present_count[32*ch +: 32] <= 32'h0;
               preset_hit[ch] <= 1'b0;
            // RQ10 software reset clear
            end else if ((soft_reset_sel[ch] & soft_reset[ch]) | hw_clr) begin
               present_count[32*ch +: 32] <= 32'h0;
               preset_hit[ch] <= 1'b0;
            // RQ6 run gate
            end else if (run[ch]) begin
               // RQ4 running count
               present_count[32*ch +: 32] <= next_count;
               // RQ5 preset reached
               preset_hit[ch] <= (up | dn) & (next_count == preset[32*ch +: 32]);
            end else begin
               preset_hit[ch] <= 1'b0;
            end
         end
         // RQ7 periodic copy
         always @(posedge mclk) begin
            if (!rst_n) begin
               refreshed_count[32*ch +: 32] <= 32'h0;
            end else if (refresh_tick) begin
               refreshed_count[32*ch +: 32] <= cur;
            end
         end
         // RQ8 speed from count change per window
         // the figure wraps like the count, so it reads as a signed step total
         always @(posedge mclk) begin
            if (!rst_n) begin
               speed[32*ch +: 32] <= 32'h0;
               speed_base[32*ch +: 32] <= 32'h0;
            end else if (speed_tick) begin
               speed[32*ch +: 32] <= cur - speed_base[32*ch +: 32];
               speed_base[32*ch +: 32] <= cur;
            end
         end
      end
   endgenerate

   // RQ7 on-demand latest read
   // a request in the cycle of a step returns the count from before that step
   always @(posedge mclk) begin
      if (!rst_n) begin
         latest_count <= 32'h0;
         latest_valid <= 1'b0;
      end else begin
         latest_valid <= read_latest_count_instruction;
         if (read_latest_count_instruction) begin
            latest_count <= present_count[32*read_chan +: 32];
         end
      end
   end

endmodule // hspc_top

// *** design/hspc_map.vh ***
// constants for the high speed pulse counter block
`ifndef HSPC_MAP_VH
`define HSPC_MAP_VH
// input method codes
`define HSPC_METH_INC 2'h0
`define HSPC_METH_QUAD 2'h1
`define HSPC_METH_UPDN 2'h2
`define HSPC_METH_PDIR 2'h3
// channel count and width
`define HSPC_NCH 4
`define HSPC_CW 32
// periodic refresh interval in ns and cycles at 100 MHz
`define HSPC_CLK_NS 10
`define HSPC_REFRESH_NS 1000000
`define HSPC_REFRESH_CYC (`HSPC_REFRESH_NS / `HSPC_CLK_NS)
// speed sample window in ns and cycles
`define HSPC_SPEED_NS 10000000
`define HSPC_SPEED_CYC (`HSPC_SPEED_NS / `HSPC_CLK_NS)
`endif

// *** tb/hspc_enc.sv ***
// encoder model on the a, b and z pins of all channels
`timescale 1ns/100ps
module hspc_enc (
   input wire mclk,
   output reg [3:0] pin_a = 4'h0,
   output reg [3:0] pin_b = 4'h0,
   output reg [3:0] pin_z = 4'h0
);
   // all pins change together; the caller keeps the spacing
   task put(input [3:0] a, input [3:0] b, input [3:0] z);
      begin
         {pin_a, pin_b, pin_z} = {a, b, z};
      end
   endtask
   task step(input [3:0] a, input [3:0] b, input [3:0] z);
      begin
         put(a, b, z);
         repeat (500) @(negedge mclk); // 50 kHz quadrature at most
      end
   endtask
   task cycle(input up);
      begin
         step({4{up}}, {4{!up}}, 4'h0);
         step(4'hf, 4'hf, 4'h0);
         step({4{!up}}, {4{up}}, 4'h0);
         step(4'h0, 4'h0, 4'h0);
      end
   endtask
endmodule // hspc_enc

// *** tb/hspc_top_sva.sv ***
// port checks on the pulse counter top
`timescale 1ns/100ps
module hspc_top_sva (
   input wire mclk,
   input wire rst_n,
   input wire [3:0] run,
   input wire [3:0] soft_reset_sel,
   input wire [3:0] soft_reset,
   input wire [127:0] preset,
   input wire read_latest_count_instruction,
   input wire [1:0] read_chan,
   input wire [127:0] present_count,
   input wire [31:0] latest_count,
   input wire latest_valid,
   input wire [3:0] preset_hit
);
   // channel 0 aliases and the count seen at a read request
   wire [31:0] c0 = present_count[31:0];
   wire rq = read_latest_count_instruction;
   reg [31:0] rd_exp;
   always @(posedge mclk) rd_exp <= present_count[32*read_chan +: 32];
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_read_data: assert property (rq |=> latest_valid && latest_count == rd_exp)
      else $error("read answer");
   a_valid_cause: assert property (latest_valid |-> $past(rq))
      else $error("stray valid");
   a_stop_hold: assert property ((!run[0] && !soft_reset[0]) [*4] |=> $stable(c0))
      else $error("halted count moved");
   a_soft_clear: assert property (soft_reset_sel[0] && soft_reset[0] |=> c0 == 32'h0)
      else $error("clear missed");
   a_hit_cause: assert property (preset_hit[0] |-> c0 == preset[31:0] && $changed(c0))
      else $error("stray hit");
   a_hit_step: assert property ($changed(c0) && c0 == preset[31:0] && c0 != 32'h0
      |-> preset_hit[0]) else $error("hit missed");
   a_step_one: assert property ($changed(c0) && c0 != 32'h0
      |-> c0 - $past(c0) == 32'h1 || $past(c0) - c0 == 32'h1) else $error("bad step");
   a_hit_pulse: assert property (preset_hit[0] |=> !preset_hit[0])
      else $error("hit too long");
endmodule // hspc_top_sva
bind hspc_top hspc_top_sva hspc_top_sva_i (.*);

// *** tb/testbench.sv ***
// self-checking bench for the pulse counter
`timescale 1ns/100ps
module testbench;
   reg mclk = 1'b0, rst_n = 1'b0, read_latest_count_instruction = 1'b0;
   reg [1:0] read_chan = 2'h0;
   reg [7:0] method = 8'he4; // channel n uses method n
   reg [3:0] run = 4'hf, soft_reset_sel = 4'h1, soft_reset = 4'h0;
   reg [127:0] preset = 128'h2; // channel 0 preset 2, the others 0
   wire [3:0] pin_a, pin_b, pin_z, preset_hit;
   wire [127:0] present_count, refreshed_count, speed;
   wire [31:0] latest_count;
   wire latest_valid;
   integer n_fail = 0, n_checks = 0, cyc = 0, n_hits = 0;
   hspc_enc hspc_enc_i (.*);
   // short windows keep the run brief
   hspc_top #(.REFRESH_CYC(20), .SPEED_CYC(50)) hspc_top_i (.*);
   // channel 0 preset pulses, looked at away from the launching edge
   always @(negedge mclk) begin
      if (preset_hit[0] === 1'b1)
         n_hits = n_hits + 1;
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: got %h", $time, got);
         end
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d fails %0d", n_checks, n_fail);
         if (n_fail == 0 && n_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   // clock, and a hang guard well past the roughly 8800 cycles needed
   initial forever #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         finish_test;
      end
   end
   // one pin pattern seen through all four methods
   task t_methods;
      begin
         hspc_enc_i.cycle(1'b1);
         chk(present_count[31:0], 32'h1);
         chk(present_count[63:32], 32'h4);
         chk(present_count[127:96], 32'hffffffff);
         hspc_enc_i.cycle(1'b0);
         chk(present_count[63:32], 32'h0);
         chk(n_hits, 32'h1);
      end
   endtask
   // back to back reads on channels 0 and 1
   task t_read;
      begin
         read_latest_count_instruction = 1'b1;
         @(negedge mclk);
         read_chan = 2'h1;
         chk(latest_count, 32'h2);
         chk({31'h0, latest_valid}, 32'h1);
         @(negedge mclk);
         read_latest_count_instruction = 1'b0;
         chk(latest_count, 32'h0);
         @(negedge mclk);
         chk({31'h0, latest_valid}, 32'h0);
      end
   endtask
   // a stopped channel keeps its count
   task t_stop;
      begin
         run = 4'h0;
         hspc_enc_i.cycle(1'b1);
         run = 4'hf;
         chk(present_count[31:0], 32'h2);
      end
   endtask
   // pin z clear waits for z, software clear does not
   task t_clear;
      begin
         soft_reset = 4'h2;
         hspc_enc_i.cycle(1'b1);
         chk(present_count[63:32], 32'h4);
         hspc_enc_i.step(4'h0, 4'h0, 4'h2);
         chk(present_count[63:32], 32'h0);
         chk(present_count[127:96], 32'hffffffff);
         soft_reset = 4'h1;
         @(negedge mclk);
         chk(present_count[31:0], 32'h0);
         // channel 0 back to pin z mode: increment mode ignores z, so it counts
         soft_reset_sel = 4'h0;
      end
   endtask
   // one pulse on every channel: speed window, refresh copy, plain-pulse wrap
   task t_speed;
      reg [31:0] n_win;
      begin
         method = 8'h24; // channel 3 moves to plain pulses
         preset[31:0] = 32'h1;
         n_win = 32'h0;
         repeat (150) @(negedge mclk);
         chk(speed[31:0], 32'h0);
         hspc_enc_i.put(4'hf, 4'h0, 4'h0);
         repeat (150) begin
            @(negedge mclk);
            if (speed[31:0] === 32'h1)
               n_win = n_win + 32'h1;
         end
         chk(n_win, 32'h32);
         chk(present_count[31:0], 32'h1);
         chk(refreshed_count[63:32], 32'h1);
         chk(present_count[127:96], 32'h0);
         chk(n_hits, 32'h2);
      end
   endtask
   initial begin
      repeat (4) @(negedge mclk);
      rst_n = 1'b1;
      t_methods;
      t_read;
      t_stop;
      t_clear;
      t_speed;
      finish_test;
   end
endmodule // testbench
